// [design/filter_if.sv]
`timescale 1ns/1ps
interface filter_if #(parameter int W = 20);
    logic raw;
    logic [W-1:0] limit;
    logic clean;
    logic rise;
    modport src(output raw, output limit, input clean, input rise);
    modport flt(input raw, input limit, output clean, output rise);
endinterface

// [design/freq_meter_channel.sv]
`timescale 1ns/1ps
module freq_meter_channel #(
    parameter int N_INPUTS = 12,
    parameter int unsigned CLK_NS = freq_meter_pkg::CLK_PERIOD_NS,
    parameter logic [31:0] WIN_10MS_CYC = 32'(freq_meter_pkg::WIN_10MS_CYC),
    parameter logic [31:0] WIN_100MS_CYC = 32'(freq_meter_pkg::WIN_100MS_CYC),
    parameter logic [31:0] WIN_1S_CYC = 32'(freq_meter_pkg::WIN_1S_CYC),
    parameter logic [31:0] WIN_60S_CYC = 32'(freq_meter_pkg::WIN_60S_CYC)
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [11:0] inputs_i,
    input wire logic [7:0] run_command_byte_i,
    input wire logic mode_simple_i,
    input wire logic [3:0] pulse_source_index_i,
    input wire logic [3:0] gate_source_index_i,
    input wire logic [3:0] pulse_debounce_time_i,
    input wire logic [7:0] pulses_per_count_i,
    input wire logic [1:0] time_base_i,
    input wire logic [15:0] preset_value_i,
    input wire logic [15:0] modulo_value_i,
    input wire logic [3:0] reflex_enable_i,
    input wire logic [31:0] reflex_low_i,
    input wire logic [31:0] reflex_high_i,
    output logic [31:0] measured_count_o,
    output logic [7:0] channel_status_byte_o,
    output logic [3:0] reflex_o
);
    localparam int FW = freq_meter_pkg::FILT_CNT_W;

    if (N_INPUTS < 1 || N_INPUTS > 12 || CLK_NS == 0) begin : g_bad_cfg
        $error("freq_meter_channel: unsupported N_INPUTS or CLK_NS");
    end

    if (CLK_NS != 0
        && freq_meter_pkg::filt_ns(4'hD) / CLK_NS >= (32'h1 << FW)) begin : g_bad_filt
        $error("freq_meter_channel: debounce time overflows filter counter");
    end

    filter_if #(.W(FW)) pf ();

    logic [7:0] cmd_prev_r;
    logic [7:0] cmd_rise;
    logic sw_enable;
    logic gate_ok;
    logic enable;
    logic pulse_raw;
    logic [7:0] presc_r;
    logic [7:0] presc_limit;
    logic count_tick;
    freq_meter_pkg::meas_state_e state_r;
    logic [31:0] win_cnt_r;
    logic [31:0] win_len;
    logic win_end;
    logic [31:0] acc_r;
    logic [31:0] result_r;
    logic result_ok_r;
    logic have_result_r;
    logic [15:0] simple_cnt_r;
    logic wrap_flag_r;
    logic load_flag_r;
    logic [31:0] win_total;
    logic [32:0] centi;

    // select pin by 1-based index; 0 or out of range means disabled
    function automatic logic pick_pin(input logic [11:0] pins, input logic [3:0] idx);
        if (idx == freq_meter_pkg::SRC_DISABLED || int'(idx) > N_INPUTS) begin
            pick_pin = 1'b0;
        end else begin
            pick_pin = pins[idx - 4'h1];
        end
    endfunction

    // hundredths of Hz = count * 100 * 1000 / window_ms; top bit flags overflow
    function automatic logic [32:0] to_centihz(input logic [31:0] cnt, input logic [1:0] tb);
        longint unsigned prod;
        longint unsigned ms;
        prod = 64'(cnt) * freq_meter_pkg::CENTI_PER_UNIT * freq_meter_pkg::MS_PER_S;
        case (tb)
            freq_meter_pkg::TB_SEL_10MS: ms = freq_meter_pkg::TB_10MS_MS;
            freq_meter_pkg::TB_SEL_100MS: ms = freq_meter_pkg::TB_100MS_MS;
            freq_meter_pkg::TB_SEL_1S: ms = freq_meter_pkg::TB_1S_MS;
            default: ms = freq_meter_pkg::TB_60S_MS;
        endcase
        prod = prod / ms;
        to_centihz = (prod > 64'h0000_0000_FFFF_FFFF) ? {1'b1, 32'hFFFF_FFFF}
                                                      : {1'b0, prod[31:0]};
    endfunction

    // command edges; reserved bits 5-7 have no effect
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_prev_r <= freq_meter_pkg::CMD_RESET;
        end else begin
            cmd_prev_r <= run_command_byte_i;
        end
    end
    assign cmd_rise = run_command_byte_i & ~cmd_prev_r;

    assign sw_enable = run_command_byte_i[freq_meter_pkg::CMD_ENABLE_BIT];
    // no gate assigned: the software bit alone decides
    assign gate_ok = (gate_source_index_i == freq_meter_pkg::SRC_DISABLED) ? 1'b1
                   : pick_pin(inputs_i, gate_source_index_i);
    assign enable = sw_enable & gate_ok;

    assign pulse_raw = pick_pin(inputs_i, pulse_source_index_i);
    assign pf.raw = pulse_raw;
    assign pf.limit = FW'(freq_meter_pkg::filt_ns(pulse_debounce_time_i) / CLK_NS);

    pulse_filter #(.W(FW)) u_pulse_filter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .f(pf)
    );

    // a setting of 0 behaves as 1 so the prescaler cannot stall
    assign presc_limit = (pulses_per_count_i == 8'h00) ? 8'h01 : pulses_per_count_i;
    assign count_tick = enable && pf.rise && (presc_r + 8'h01 >= presc_limit);

    always_ff @(posedge clk_i) begin
        if (reset_i || !enable) begin
            presc_r <= 8'h00;
        end else if (pf.rise) begin
            presc_r <= count_tick ? 8'h00 : presc_r + 8'h01;
        end
    end

    // window length
    always_comb begin
        unique case (time_base_i)
            freq_meter_pkg::TB_SEL_10MS: win_len = WIN_10MS_CYC;
            freq_meter_pkg::TB_SEL_100MS: win_len = WIN_100MS_CYC;
            freq_meter_pkg::TB_SEL_1S: win_len = WIN_1S_CYC;
            freq_meter_pkg::TB_SEL_60S: win_len = WIN_60S_CYC;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= freq_meter_pkg::MEAS_IDLE;
        end else begin
            unique case (state_r)
                freq_meter_pkg::MEAS_IDLE: if (enable) state_r <= freq_meter_pkg::MEAS_RUN;
                freq_meter_pkg::MEAS_RUN: if (!enable) state_r <= freq_meter_pkg::MEAS_IDLE;
                default: state_r <= freq_meter_pkg::MEAS_IDLE;
            endcase
        end
    end

    assign win_end = (state_r == freq_meter_pkg::MEAS_RUN) && enable && !mode_simple_i
                     && (win_cnt_r + 32'h1 >= win_len);
    assign win_total = acc_r + {31'h0, count_tick};
    assign centi = to_centihz(win_total, time_base_i);

    always_ff @(posedge clk_i) begin
        if (reset_i || state_r != freq_meter_pkg::MEAS_RUN || !enable || mode_simple_i) begin
            win_cnt_r <= 32'h0;
            acc_r <= 32'h0;
        end else if (win_end) begin
            win_cnt_r <= 32'h0;
            acc_r <= 32'h0;
        end else begin
            win_cnt_r <= win_cnt_r + 32'h1;
            acc_r <= win_total;
        end
    end

    // result holds between windows; validity drops with enable
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            result_r <= 32'h0;
            result_ok_r <= 1'b0;
            have_result_r <= 1'b0;
        end else if (win_end) begin
            result_r <= centi[31:0];
            result_ok_r <= ~centi[32];
            have_result_r <= 1'b1;
        end else if (!enable) begin
            have_result_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reflex_o <= 4'h0;
        end else if (win_end) begin
            reflex_o[0] <= reflex_enable_i[0] & (centi[31:0] < reflex_low_i);
            reflex_o[1] <= reflex_enable_i[1] & (centi[31:0] >= reflex_low_i)
                           & (centi[31:0] <= reflex_high_i);
            reflex_o[2] <= reflex_enable_i[2] & (centi[31:0] > reflex_high_i);
            reflex_o[3] <= reflex_enable_i[3] & ~centi[32];
        end
    end

    // simple counting: load, clear and modulo wrap; clear beats load beats count
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            simple_cnt_r <= 16'h0000;
        end else if (cmd_rise[freq_meter_pkg::CMD_CLR_COUNT_BIT]) begin
            simple_cnt_r <= 16'h0000;
        end else if (cmd_rise[freq_meter_pkg::CMD_LOAD_BIT]) begin
            simple_cnt_r <= preset_value_i;
        end else if (mode_simple_i && count_tick) begin
            simple_cnt_r <= (simple_cnt_r >= modulo_value_i) ? 16'h0000
                                                              : simple_cnt_r + 16'h0001;
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wrap_flag_r <= 1'b0;
        end else if (mode_simple_i && count_tick && simple_cnt_r >= modulo_value_i
                     && !cmd_rise[freq_meter_pkg::CMD_CLR_COUNT_BIT]
                     && !cmd_rise[freq_meter_pkg::CMD_LOAD_BIT]) begin
            wrap_flag_r <= 1'b1;
        end else if (cmd_rise[freq_meter_pkg::CMD_ACK_WRAP_BIT]) begin
            wrap_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            load_flag_r <= 1'b0;
        end else if (cmd_rise[freq_meter_pkg::CMD_LOAD_BIT]) begin
            load_flag_r <= 1'b1;
        end else if (cmd_rise[freq_meter_pkg::CMD_ACK_LOAD_BIT]) begin
            load_flag_r <= 1'b0;
        end
    end

    // outputs registered each cycle so the bus head always sees fresh data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            measured_count_o <= 32'h0;
            channel_status_byte_o <= freq_meter_pkg::STATUS_RESET;
        end else begin
            measured_count_o <= mode_simple_i ? {16'h0000, simple_cnt_r} : result_r;
            channel_status_byte_o <= 8'h00;
            channel_status_byte_o[freq_meter_pkg::ST_RUN_BIT] <= enable;
            channel_status_byte_o[freq_meter_pkg::ST_VALID_BIT] <= enable
                && (mode_simple_i || (have_result_r && result_ok_r));
            channel_status_byte_o[freq_meter_pkg::ST_WRAP_BIT] <= wrap_flag_r;
            channel_status_byte_o[freq_meter_pkg::ST_LOAD_BIT] <= load_flag_r;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    run_bit_follows_a: assert property (##1 channel_status_byte_o[0] == $past(enable))
        else $error("run bit does not follow enable");
    gate_and_a: assert property ((gate_source_index_i != 4'h0 && !gate_ok) |-> !enable)
        else $error("enable true while gate low");
    sw_enable_a: assert property (!run_command_byte_i[0] |=> !channel_status_byte_o[0])
        else $error("run bit set without software enable");
    load_flag_set_a: assert property (cmd_rise[1] |=> load_flag_r ##1 channel_status_byte_o[3])
        else $error("load flag not raised");
    load_ack_a: assert property (cmd_rise[3] && !cmd_rise[1] |=> !load_flag_r)
        else $error("load flag not cleared");
    wrap_ack_a: assert property (cmd_rise[2] && !count_tick |=> !wrap_flag_r)
        else $error("wrap flag not cleared");
    wrap_set_a: assert property (count_tick && mode_simple_i
                                 && simple_cnt_r >= modulo_value_i && !cmd_rise[4]
                                 && !cmd_rise[1] |=> wrap_flag_r && simple_cnt_r == 16'h0000)
        else $error("wrap flag not raised on loop back");
    count_clear_a: assert property (cmd_rise[4] |=> simple_cnt_r == 16'h0000 ##1
                                     (!mode_simple_i || measured_count_o == 32'h0))
        else $error("counter not zeroed");
    preset_load_a: assert property (cmd_rise[1] && !cmd_rise[4] |=>
                                    simple_cnt_r == $past(preset_value_i))
        else $error("preset not loaded");
    window_publish_a: assert property (win_end |=> result_r == $past(centi[31:0])
                                       && win_cnt_r == 32'h0 && acc_r == 32'h0)
        else $error("window end did not publish and restart");
    disabled_pulse_a: assert property (pulse_source_index_i == 4'h0 |-> !pulse_raw)
        else $error("disabled pulse source passes pulses");
    valid_drop_a: assert property (!enable |=> !channel_status_byte_o[1])
        else $error("valid bit set while not running");

    window_seen_c: cover property (win_end ##1 channel_status_byte_o[1]);
    wrap_seen_c: cover property (wrap_flag_r && mode_simple_i);
    gate_stop_c: cover property (sw_enable && !gate_ok && state_r == freq_meter_pkg::MEAS_RUN);
    reflex_seen_c: cover property (win_end ##1 reflex_o[1]);
endmodule

// [design/freq_meter_pkg.sv]
package freq_meter_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned FILT_CNT_W = 20;
    localparam logic [3:0] FILT_DEFAULT_IDX = 4'h3;
    localparam logic [7:0] PULSES_PER_COUNT_DEFAULT = 8'h01;
    localparam logic [3:0] SRC_DISABLED = 4'h0;
    localparam int unsigned CMD_ENABLE_BIT = 0;
    localparam int unsigned CMD_LOAD_BIT = 1;
    localparam int unsigned CMD_ACK_WRAP_BIT = 2;
    localparam int unsigned CMD_ACK_LOAD_BIT = 3;
    localparam int unsigned CMD_CLR_COUNT_BIT = 4;
    localparam int unsigned ST_RUN_BIT = 0;
    localparam int unsigned ST_VALID_BIT = 1;
    localparam int unsigned ST_WRAP_BIT = 2;
    localparam int unsigned ST_LOAD_BIT = 3;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] TB_SEL_10MS = 2'h0;
    localparam logic [1:0] TB_SEL_100MS = 2'h1;
    localparam logic [1:0] TB_SEL_1S = 2'h2;
    localparam logic [1:0] TB_SEL_60S = 2'h3;
    localparam longint unsigned TB_10MS_MS = 10;
    localparam longint unsigned TB_100MS_MS = 100;
    localparam longint unsigned TB_1S_MS = 1000;
    localparam longint unsigned TB_60S_MS = 60000;
    localparam longint unsigned NS_PER_MS = 1000000;
    localparam longint unsigned MS_PER_S = 1000;
    localparam longint unsigned CENTI_PER_UNIT = 100;
    localparam longint unsigned WIN_10MS_CYC = TB_10MS_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam longint unsigned WIN_100MS_CYC = TB_100MS_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam longint unsigned WIN_1S_CYC = TB_1S_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam longint unsigned WIN_60S_CYC = TB_60S_MS * NS_PER_MS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b01,
        MEAS_RUN = 2'b10
    } meas_state_e;

    // debounce settings in ns, index 0 is no filtering
    function automatic int unsigned filt_ns(input logic [3:0] idx);
        case (idx)
            4'h0: filt_ns = 0;
            4'h1: filt_ns = 500;
            4'h2: filt_ns = 1000;
            4'h3: filt_ns = 2000;
            4'h4: filt_ns = 5000;
            4'h5: filt_ns = 10000;
            4'h6: filt_ns = 50000;
            4'h7: filt_ns = 100000;
            4'h8: filt_ns = 250000;
            4'h9: filt_ns = 500000;
            4'hA: filt_ns = 1000000;
            4'hB: filt_ns = 2000000;
            4'hC: filt_ns = 4000000;
            default: filt_ns = 12000000;
        endcase
    endfunction
endpackage

// [design/pulse_filter.sv]
`timescale 1ns/1ps
module pulse_filter #(
    parameter int W = 20
) (
    input wire logic clk_i,
    input wire logic reset_i,
    filter_if.flt f
);
    logic [W-1:0] stable_cnt_r;
    logic clean_r;
    logic clean_prev_r;

    // new level is taken only after it held for limit cycles
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stable_cnt_r <= '0;
            clean_r <= 1'b0;
        end else if (f.raw == clean_r) begin
            stable_cnt_r <= '0;
        end else if (stable_cnt_r + 1'b1 >= f.limit) begin
            clean_r <= f.raw;
            stable_cnt_r <= '0;
        end else begin
            stable_cnt_r <= stable_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clean_prev_r <= 1'b0;
        end else begin
            clean_prev_r <= clean_r;
        end
    end

    assign f.clean = clean_r;
    assign f.rise = clean_r & ~clean_prev_r;
endmodule

// [test/bus_head_model.sv]
`timescale 1ns/1ps
// cyclic process-data exchange seen from the bus head side
module bus_head_model (
    input wire logic clk_i,
    input wire logic [7:0] cmd_i,
    input wire logic [31:0] measured_count_i,
    input wire logic [7:0] channel_status_byte_i,
    output logic [7:0] run_command_byte_o,
    output logic [31:0] image_count_o,
    output logic [7:0] image_status_o
);
    initial run_command_byte_o = 8'h00;
    initial image_count_o = 32'h00000000;
    initial image_status_o = 8'h00;

    // reserved command bits always sent as zero, never relied on
    always @(negedge clk_i) begin
        run_command_byte_o <= {3'h0, cmd_i[4:0]};
    end

    // image refreshed every bus cycle, so it lags the device by one edge
    always @(posedge clk_i) begin
        image_count_o <= measured_count_i;
        image_status_o <= channel_status_byte_i;
    end
endmodule

// [test/freq_meter_channel_tb_top.sv]
`timescale 1ns/1ps
module freq_meter_channel_tb_top;
    localparam int WIN = 200;
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] in_r = 12'h000;
    logic [7:0] cmd_r = 8'h00;
    logic mode_simple_r = 1'b1;
    logic [3:0] pulse_idx_r = 4'h3;
    logic [3:0] gate_idx_r = 4'h0;
    logic [3:0] debounce_r = 4'h0;
    logic [7:0] ppc_r = 8'h01;
    logic [1:0] time_base_r = 2'h0;
    // thresholds chosen so the four windows hit above, both edges of, and below the band
    logic [31:0] low_r = 32'h0000012C;
    logic [31:0] high_r = 32'h00000BB8;
    logic [3:0] refl_en_r = 4'hF;
    logic [7:0] cmd_byte;
    logic [31:0] count_o;
    logic [7:0] status_o;
    logic [3:0] reflex_o;
    logic [31:0] img_count;
    logic [7:0] img_status;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    longint unsigned win_ms [4] = '{10, 100, 1000, 60000};

    always #10 clk_i = ~clk_i;

    freq_meter_channel #(.N_INPUTS(12), .CLK_NS(2000), .WIN_10MS_CYC(32'(WIN)),
        .WIN_100MS_CYC(32'(WIN)), .WIN_1S_CYC(32'(WIN)), .WIN_60S_CYC(32'(WIN))) uut (
        .clk_i(clk_i), .reset_i(reset_i), .inputs_i(in_r), .run_command_byte_i(cmd_byte),
        .mode_simple_i(mode_simple_r), .pulse_source_index_i(pulse_idx_r),
        .gate_source_index_i(gate_idx_r), .pulse_debounce_time_i(debounce_r),
        .pulses_per_count_i(ppc_r), .time_base_i(time_base_r), .preset_value_i(16'h1234),
        .modulo_value_i(16'h0003), .reflex_enable_i(refl_en_r), .reflex_low_i(low_r),
        .reflex_high_i(high_r), .measured_count_o(count_o),
        .channel_status_byte_o(status_o), .reflex_o(reflex_o));

    bus_head_model head (.clk_i(clk_i), .cmd_i(cmd_r), .measured_count_i(count_o),
        .channel_status_byte_i(status_o), .run_command_byte_o(cmd_byte),
        .image_count_o(img_count), .image_status_o(img_status));

    task automatic stop_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // model adds one cycle each way, device two more; five leaves margin
    task automatic set_cmd(input logic [7:0] b);
        cmd_r <= b;
        tick(5);
    endtask

    task automatic pulse(input int bit_n, input int high_cyc);
        in_r[bit_n] <= 1'b1;
        tick(high_cyc);
        in_r[bit_n] <= 1'b0;
        tick(4);
    endtask

    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            pulse(2, 3);
        end
        tick(4);
    endtask

    task automatic wait_valid();
        int k;
        k = 0;
        while (img_status[1] !== 1'b1 && k < 3 * WIN) begin
            tick(1);
            k++;
        end
        tick(2);
    endtask

    function automatic logic [31:0] refl(input logic [31:0] r);
        refl = {28'h0, 1'b1, r > high_r, r >= low_r && r <= high_r, r < low_r};
    endfunction

    initial begin
        tick(8);
        reset_i <= 1'b0;
        tick(3);
        chk_word(img_count, 32'h00000000);
        chk_word({24'h0, img_status}, 32'h00000000);
        set_cmd(8'h02);
        chk_word(img_count, 32'h00001234);
        chk_bit(img_status[3], 1'b1);
        set_cmd(8'h0A);
        chk_bit(img_status[3], 1'b0);
        set_cmd(8'h00);
        set_cmd(8'h10);
        chk_word(img_count, 32'h00000000);
        set_cmd(8'h01);
        chk_bit(img_status[0], 1'b1);
        pulses(3);
        chk_word(img_count, 32'h00000003);
        pulses(1);
        chk_word(img_count, 32'h00000000);
        chk_bit(img_status[2], 1'b1);
        set_cmd(8'h05);
        chk_bit(img_status[2], 1'b0);
        set_cmd(8'h01);
        // filter index 5 needs five stable cycles at this clock
        debounce_r <= 4'h5;
        pulse(2, 2);
        tick(8);
        chk_word(img_count, 32'h00000000);
        pulse(2, 10);
        tick(8);
        chk_word(img_count, 32'h00000001);
        debounce_r <= 4'h0;
        gate_idx_r <= 4'h5;
        tick(4);
        chk_bit(img_status[0], 1'b0);
        in_r[4] <= 1'b1;
        tick(4);
        chk_bit(img_status[0], 1'b1);
        gate_idx_r <= 4'h0;
        set_cmd(8'h00);
        chk_bit(img_status[0], 1'b0);
        pulses(2);
        chk_word(img_count, 32'h00000001);
        mode_simple_r <= 1'b0;
        ppc_r <= 8'h02;
        for (int ts = 0; ts < 4; ts++) begin
            time_base_r <= 2'(ts);
            set_cmd(8'h01);
            pulses(6);
            wait_valid();
            chk_word(img_count, 32'(3 * 100000 / win_ms[ts]));
            chk_word({28'h0, reflex_o}, refl(32'(3 * 100000 / win_ms[ts])));
            set_cmd(8'h00);
            chk_bit(img_status[1], 1'b0);
        end
        pulse_idx_r <= 4'h0;
        refl_en_r <= 4'h7;
        set_cmd(8'h01);
        pulses(6);
        wait_valid();
        chk_word(img_count, 32'h00000000);
        chk_word({28'h0, reflex_o}, refl(32'h00000000) & 32'h00000007);
        stop_test();
    end
endmodule
